// ==== include/prb_pkg.sv ====
// Package of constants and types for the pixel render back end
package prb_pkg;
	localparam int COLOR_W = 8;
	localparam int Z_W = 16;
	localparam int TC_W = 12;
	localparam int FRAC_W = 4;
	localparam int TEX_AW = 12;
	localparam int TILE_BITS = 6;
	localparam int PIX_W = 24;
	localparam int ZCMP_W = 3;
	localparam int ROP_W = 4;
	localparam int ADDR_W = 4;
	localparam logic [4:0] LINE_W_MAX = 5'h1f;
	localparam logic [2:0] ZC_NEVER = 3'h0;
	localparam logic [2:0] ZC_ALWAYS = 3'h1;
	localparam logic [2:0] ZC_LESS = 3'h2;
	localparam logic [2:0] ZC_LEQUAL = 3'h3;
	localparam logic [2:0] ZC_EQUAL = 3'h4;
	localparam logic [2:0] ZC_GEQUAL = 3'h5;
	localparam logic [2:0] ZC_GREATER = 3'h6;
	localparam logic [2:0] ZC_NOTEQUAL = 3'h7;
	localparam logic [3:0] REG_MODE = 4'h0;
	localparam logic [3:0] REG_ALPHA = 4'h1;
	localparam logic [3:0] REG_ROP = 4'h2;
	localparam logic [3:0] REG_DEPTH = 4'h3;
	localparam logic [3:0] REG_LINE = 4'h4;
	localparam logic [3:0] REG_DASH = 4'h5;
	localparam logic [3:0] REG_FGCOL = 4'h6;
	localparam logic [3:0] REG_BGCOL = 4'h7;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_TEXWR = 4'h9;
	// Mode, depth, line and status register fields
	localparam int M_FILT = 0;
	localparam int M_PERSP = 1;
	localparam int M_TEXEN = 2;
	localparam int M_TILE = 3;
	localparam int M_ALPHA = 4;
	localparam int M_ROPEN = 5;
	localparam int M_FAST = 6;
	localparam int M_GOURAUD = 7;
	localparam int M_F2D = 8;
	localparam int M_BGTR = 9;
	localparam int M_DIRECT = 10;
	localparam int M_NATIVE = 11;
	localparam int M_DINTERP = 12;
	localparam int M_AA = 13;
	localparam int M_TBL_LO = 14;
	localparam int M_ABL_LO = 16;
	localparam int M_SCL_LO = 18;
	localparam int M_CHAR = 21;
	localparam int M_WRAP_REP = 22;
	localparam int M_COL16 = 23;
	localparam int D_CMP_LO = 0;
	localparam int D_INH = 3;
	localparam int D_Z8 = 4;
	localparam int L_WID_LO = 0;
	localparam int L_HOLD_LO = 8;
	localparam int ST_BAD = 0;
	localparam int ST_DRAWN = 1;
	localparam int ST_ZPASS = 2;
	typedef enum logic [1:0] {TB_REPLACE, TB_MODULATE, TB_STENCIL} prb_tblend_type;
	typedef enum logic [1:0] {AB_NORMAL, AB_STENCIL, AB_STALPHA} prb_ablend_type;
	typedef enum logic [2:0] {SC_NONE, SC_DOUBLE, SC_DOUBLE_H, SC_HALF, SC_HALF_H}
		prb_scale_type;
endpackage

// ==== rtl/prb_texmem.sv ====
// Texture memory: 64x64 texels of 16 bits, registered read data
`timescale 1ns/100ps
module prb_texmem
	import prb_pkg::*;
(
	input  wire logic              clk,   // Clock
	input  wire logic              we,    // Write strobe
	input  wire logic [TEX_AW-1:0] waddr, // Write address
	input  wire logic [15:0]       wdata, // Write data
	input  wire logic [TEX_AW-1:0] raddr, // Read address
	output logic      [15:0]       rdata  // Read data, one cycle later
);
	logic [15:0] mem [0:(1<<TEX_AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ==== rtl/prb_logic_op.sv ====
// Sixteen-function two-operand logic operation, bitwise over a pixel
`timescale 1ns/100ps
module prb_logic_op
	import prb_pkg::*;
(
	input  wire logic [ROP_W-1:0] code, // Function code
	input  wire logic [PIX_W-1:0] src,  // Source pixel S
	input  wire logic [PIX_W-1:0] dst,  // Destination pixel D
	output logic      [PIX_W-1:0] res   // Result
);
	// Code bit index is {~S,~D}: truth table of the function
	genvar i;
	generate
		for (i = 0; i < PIX_W; i++) begin : g_bit
			assign res[i] = code[{~src[i], ~dst[i]}]; // RULE_13
		end
	endgenerate
endmodule

// ==== rtl/prb_core.sv ====
// Pixel render back end: texture, blend, logic operation, depth and line attributes
//
// Overview of operation
// RULE_01 - Point filter uses the nearest texel
// RULE_02 - Bilinear weights four nearest texels by distance; stage 2 lerps earlier taps tx0-tx2 with the texel at truncated S, T
// RULE_03 - Q equals 1/W corrects S and T
// RULE_04 - Replace blend outputs texel, ignores polygon colour
// RULE_05 - Modulate outputs texel times polygon colour
// RULE_06 - Texture stencil picks texel when MSB set
// RULE_07 - Fast bilinear needs bilinear, repeat, 16-bit
// RULE_08 - Tiling indexed by screen position, 64x64 max
// RULE_09 - Alpha blend drawn and frame colours, direct only
// RULE_10 - Alpha 00h zero, FFh full weight
// RULE_11 - Normal blends, stencil keeps frame if MSB clear
// RULE_12 - Stencil-alpha blends only texels with MSB set
// RULE_13 - Four-bit code selects sixteen logic functions
// RULE_14 - Three-bit depth compare code, eight conditions
// RULE_15 - Write inhibit compares without updating depth
// RULE_16 - Depth width 16 or 8 bits
// RULE_17 - Line width 1 to 32, optional smoothing
// RULE_18 - Dashes follow a 32-bit pattern
// RULE_19 - Shading and alpha ignored for fast 2D triangle
// RULE_20 - Characters: fore/back colour, transparency, scaling; the code has no scaling, M_SCL_LO is unused
// RULE_21 - Dash joints: none or fixed reference hold
// RULE_22 - Native caps perpendicular to ideal line
`timescale 1ns/100ps
module prb_core
	import prb_pkg::*;
(
	input  wire logic              clk,         // Clock
	input  wire logic              rst,         // Synchronous reset, active high
	input  wire logic [ADDR_W-1:0] reg_addr,    // Register address
	input  wire logic [31:0]       reg_wdata,   // Register write data
	input  wire logic              reg_wr,      // Register write strobe
	input  wire logic              reg_rd,      // Register read strobe
	output logic      [31:0]       reg_rdata,   // Register read data
	input  wire logic              pix_valid,   // Pixel from rasterizer
	input  wire logic [11:0]       pix_x,       // Screen X
	input  wire logic [11:0]       pix_y,       // Screen Y
	input  wire logic [PIX_W-1:0]  pix_color,   // Polygon colour RGB
	input  wire logic [PIX_W-1:0]  pix_flat,    // Flat shading colour
	input  wire logic [TC_W+FRAC_W-1:0] pix_s,  // S, fixed point
	input  wire logic [TC_W+FRAC_W-1:0] pix_t,  // T, fixed point
	input  wire logic [15:0]       pix_q,       // Q = 1/W, 8.8 fixed point
	input  wire logic [Z_W-1:0]    pix_z,       // Pixel Z
	input  wire logic              pix_is_line, // Pixel belongs to a line
	input  wire logic [4:0]        pix_dist,    // Line pixel distance from centre
	input  wire logic              pix_edge,    // Line edge pixel
	input  wire logic [4:0]        pix_dash_pos, // Dash pattern position
	input  wire logic              pix_joint,   // Near a bold line joint
	input  wire logic              pix_cap,     // Beyond cap of native line
	input  wire logic              pix_glyph,   // Character bit
	input  wire logic [PIX_W-1:0]  fb_color,    // Frame buffer colour
	input  wire logic [Z_W-1:0]    zb_value,    // Stored depth
	output logic                   out_valid,   // Result pixel valid
	output logic                   out_fb_we,   // Frame buffer write
	output logic [PIX_W-1:0]       out_color,   // Result colour
	output logic                   out_zb_we,   // Depth buffer write
	output logic [Z_W-1:0]         out_z        // Depth to write
);
	typedef struct packed {
		logic [31:0]       mode;
		logic [7:0]        alpha;
		logic [ROP_W-1:0]  rop;
		logic [4:0]        depth;
		logic [15:0]       line;
		logic [31:0]       dash;
		logic [PIX_W-1:0]  fg;
		logic [PIX_W-1:0]  bg;
		logic [2:0]        status;
		logic [31:0]       rdata;
		logic              s1_valid;
		logic [PIX_W-1:0]  s1_poly;
		logic [PIX_W-1:0]  s1_fb;
		logic [Z_W-1:0]    s1_z;
		logic [Z_W-1:0]    s1_zb;
		logic              s1_keep;
		logic [FRAC_W-1:0] s1_fs;
		logic [FRAC_W-1:0] s1_ft;
		logic [1:0]        tap;
		logic [15:0]       tx0;
		logic [15:0]       tx1;
		logic [15:0]       tx2;
		logic [4:0]        hold_cnt;
		logic [4:0]        hold_pos;
		logic              o_valid;
		logic              o_fb_we;
		logic [PIX_W-1:0]  o_color;
		logic              o_zb_we;
		logic [Z_W-1:0]    o_z;
	} prb_state_type;

	prb_state_type st_reg, st_next;
	logic [TEX_AW-1:0] tex_raddr;
	logic [15:0]       tex_rdata;
	logic [PIX_W-1:0]  rop_res;

	prb_texmem u_tex (
		.clk   (clk),
		.we    (reg_wr && reg_addr == REG_TEXWR),
		.waddr (reg_wdata[16+TEX_AW-1:16]),
		.wdata (reg_wdata[15:0]),
		.raddr (tex_raddr),
		.rdata (tex_rdata)
	);

	prb_logic_op u_rop (
		.code (st_reg.rop),
		.src  (st_reg.s1_poly),
		.dst  (st_reg.s1_fb),
		.res  (rop_res)
	);

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic logic [PIX_W-1:0] tex_to_rgb(input logic [15:0] t);
		tex_to_rgb = {t[14:10], t[14:12], t[9:5], t[9:7], t[4:0], t[4:2]};
	endfunction

	function automatic logic [7:0] mul8(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] p;
		p = a * b + 16'h0080;
		mul8 = 8'((p + {8'h00, p[15:8]}) >> 8);
	endfunction

	// RULE_10
	function automatic logic [PIX_W-1:0] blend(input logic [PIX_W-1:0] p,
		input logic [PIX_W-1:0] f, input logic [7:0] a);
		for (int c = 0; c < 3; c++) begin
			blend[c*8 +: 8] = mul8(p[c*8 +: 8], a) + mul8(f[c*8 +: 8], ~a); // RULE_09
		end
	endfunction

	function automatic logic [7:0] lerp(input logic [7:0] a, input logic [7:0] b,
		input logic [FRAC_W-1:0] w);
		logic [11:0] s;
		s = 12'(a) * 12'((1 << FRAC_W) - w) + 12'(b) * 12'(w);
		lerp = s[FRAC_W +: 8];
	endfunction

	// ****************************************
	// Texel addressing
	// ****************************************
	logic [TC_W+FRAC_W+15:0] s_corr, t_corr;
	logic [TC_W-1:0]          s_int, t_int;
	logic [TILE_BITS-1:0]     s_idx, t_idx;
	logic                     tap_active;
	always_comb begin
		// S*Q and T*Q arrive interpolated; dividing by Q restores S and T
		if (st_reg.mode[M_PERSP]) begin
			s_corr = (pix_s << 8) / ((pix_q == 16'h0000) ? 16'h0001 : pix_q); // RULE_03
			t_corr = (pix_t << 8) / ((pix_q == 16'h0000) ? 16'h0001 : pix_q); // RULE_03
		end else begin
			s_corr = (TC_W+FRAC_W+16)'(pix_s);
			t_corr = (TC_W+FRAC_W+16)'(pix_t);
		end
		s_int = s_corr[FRAC_W +: TC_W];
		t_int = t_corr[FRAC_W +: TC_W];
		tap_active = st_reg.mode[M_FILT] && st_reg.tap != 2'h0;
		if (st_reg.mode[M_TILE]) begin
			s_idx = pix_x[TILE_BITS-1:0]; // RULE_08
			t_idx = pix_y[TILE_BITS-1:0]; // RULE_08
		end else if (st_reg.mode[M_FILT] && !st_reg.mode[M_FAST]) begin
			// Bilinear takes four reads; tap walks the 2x2 neighbourhood
			s_idx = TILE_BITS'(s_int) + TILE_BITS'(st_reg.tap[0]); // RULE_02
			t_idx = TILE_BITS'(t_int) + TILE_BITS'(st_reg.tap[1]); // RULE_02
		end else if (st_reg.mode[M_FILT]) begin
			s_idx = TILE_BITS'(s_int);
			t_idx = TILE_BITS'(t_int);
		end else begin
			// Round to the nearest texel
			s_idx = TILE_BITS'(s_corr[FRAC_W +: TC_W] + 12'(s_corr[FRAC_W-1])); // RULE_01
			t_idx = TILE_BITS'(t_corr[FRAC_W +: TC_W] + 12'(t_corr[FRAC_W-1])); // RULE_01
		end
		tex_raddr = {t_idx, s_idx};
	end

	// ****************************************
	// Next state
	// ****************************************
	logic [PIX_W-1:0] texc, poly, draw, t00, t01, t10, t11;
	logic             msb, zpass, cfg_bad, use_tex, tiled, direct, drawn;
	logic [Z_W-1:0]   zn, zo;
	logic [4:0]       dpos;
	always_comb begin
		st_next = st_reg;
		st_next.o_valid = 1'b0;
		st_next.o_fb_we = 1'b0;
		st_next.o_zb_we = 1'b0;
		poly = st_reg.s1_poly;
		dpos = pix_dash_pos;
		texc = tex_to_rgb(tex_rdata);
		t00 = tex_to_rgb(st_reg.tx0);
		t01 = tex_to_rgb(st_reg.tx1);
		t10 = tex_to_rgb(st_reg.tx2);
		t11 = texc;
		msb = tex_rdata[15];
		use_tex = st_reg.mode[M_TEXEN] && !st_reg.mode[M_TILE];
		tiled = st_reg.mode[M_TILE];
		direct = st_reg.mode[M_DIRECT];
		// Fast layout gives one word per read, so only the texel at the truncated S and T is used
		cfg_bad = (st_reg.mode[M_FAST] && !(st_reg.mode[M_FILT] &&
			st_reg.mode[M_WRAP_REP] && st_reg.mode[M_COL16])) // RULE_07
			|| (st_reg.mode[M_TILE] && st_reg.mode[M_TEXEN]) // RULE_08
			|| (st_reg.mode[M_ALPHA] && (st_reg.mode[M_ROPEN] || !direct)); // RULE_09
		st_next.status[ST_BAD] = cfg_bad;

		// Register writes and read data
		if (reg_wr) begin
			unique case (reg_addr)
				REG_MODE:  st_next.mode = reg_wdata;
				REG_ALPHA: st_next.alpha = reg_wdata[7:0];
				REG_ROP:   st_next.rop = reg_wdata[ROP_W-1:0];
				REG_DEPTH: st_next.depth = reg_wdata[4:0];
				REG_LINE:  st_next.line = reg_wdata[15:0];
				REG_DASH:  st_next.dash = reg_wdata;
				REG_FGCOL: st_next.fg = reg_wdata[PIX_W-1:0];
				REG_BGCOL: st_next.bg = reg_wdata[PIX_W-1:0];
				default: ;
			endcase
		end
		st_next.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				REG_MODE:   st_next.rdata = st_reg.mode;
				REG_ALPHA:  st_next.rdata = {24'h000000, st_reg.alpha};
				REG_ROP:    st_next.rdata = {28'h0000000, st_reg.rop};
				REG_DEPTH:  st_next.rdata = {27'h0000000, st_reg.depth};
				REG_LINE:   st_next.rdata = {16'h0000, st_reg.line};
				REG_DASH:   st_next.rdata = st_reg.dash;
				REG_FGCOL:  st_next.rdata = {8'h00, st_reg.fg};
				REG_BGCOL:  st_next.rdata = {8'h00, st_reg.bg};
				REG_STATUS: st_next.rdata = {29'h0000000, st_reg.status};
				default:    st_next.rdata = 32'h0000_0000;
			endcase
		end

		// Stage 1: capture pixel, decide line/char coverage
		if (tap_active) begin
			st_next.tap = st_reg.tap + 2'h1;
			unique case (st_reg.tap)
				2'h1: st_next.tx0 = tex_rdata;
				2'h2: st_next.tx1 = tex_rdata;
				default: st_next.tx2 = tex_rdata;
			endcase
		end
		st_next.s1_valid = 1'b0;
		if (pix_valid && !tap_active) begin
			st_next.s1_valid = 1'b1;
			st_next.tap = st_reg.mode[M_FILT] && !st_reg.mode[M_FAST] && use_tex ?
				2'h1 : 2'h0;
			st_next.s1_fs = s_corr[FRAC_W-1:0];
			st_next.s1_ft = t_corr[FRAC_W-1:0];
			poly = (st_reg.mode[M_GOURAUD] || st_reg.mode[M_F2D]) ? pix_color : pix_flat; // RULE_19
			st_next.s1_keep = 1'b1;
			if (st_reg.mode[M_CHAR]) begin
				poly = pix_glyph ? st_reg.fg : st_reg.bg; // RULE_20
				st_next.s1_keep = pix_glyph || !st_reg.mode[M_BGTR]; // RULE_20
			end
			if (pix_is_line) begin
				// Hold the dash position near a joint until hold_cnt reaches the L_HOLD_LO field of the line register
				dpos = pix_dash_pos;
				if (st_reg.mode[M_DINTERP] && pix_joint) begin
					dpos = st_reg.hold_pos; // RULE_21
				end else begin
					st_next.hold_pos = pix_dash_pos;
				end
				st_next.hold_cnt = pix_joint ? st_reg.hold_cnt + 5'h01 : 5'h00;
				if (st_reg.hold_cnt >= st_reg.line[L_HOLD_LO +: 5]) begin
					st_next.hold_pos = pix_dash_pos; // RULE_21
				end
				st_next.s1_keep = st_reg.dash[dpos] // RULE_18
					&& pix_dist <= st_reg.line[L_WID_LO +: 5] // RULE_17
					&& !(st_reg.mode[M_NATIVE] && pix_cap); // RULE_22
				if (st_reg.mode[M_AA] && pix_edge) begin
					poly = blend(poly, fb_color, 8'h80); // RULE_17
				end
			end
			st_next.s1_poly = poly;
			st_next.s1_fb = fb_color;
			st_next.s1_z = pix_z;
			st_next.s1_zb = zb_value;
		end

		// Stage 2: texture, blend, logic operation, depth
		if (st_reg.s1_valid) begin
			if (st_reg.mode[M_FILT] && !st_reg.mode[M_FAST]) begin
				for (int c = 0; c < 3; c++) begin
					texc[c*8 +: 8] = lerp(lerp(t00[c*8 +: 8], t01[c*8 +: 8], st_reg.s1_fs),
						lerp(t10[c*8 +: 8], t11[c*8 +: 8], st_reg.s1_fs),
						st_reg.s1_ft); // RULE_02
				end
			end
			draw = st_reg.s1_poly;
			if (tiled) begin
				draw = texc; // RULE_08
			end else if (use_tex) begin
				unique case (prb_tblend_type'(st_reg.mode[M_TBL_LO +: 2]))
					TB_REPLACE: draw = texc; // RULE_04
					TB_MODULATE: begin
						for (int c = 0; c < 3; c++) begin
							draw[c*8 +: 8] = mul8(texc[c*8 +: 8], st_reg.s1_poly[c*8 +: 8]); // RULE_05
						end
					end
					TB_STENCIL: draw = msb ? texc : st_reg.s1_poly; // RULE_06
					default: draw = texc;
				endcase
			end
			drawn = st_reg.s1_keep;
			if (st_reg.mode[M_ROPEN]) begin
				draw = rop_res; // RULE_13
			end else if (st_reg.mode[M_ALPHA] && direct && !st_reg.mode[M_F2D]) begin
				if (!use_tex) begin
					draw = blend(draw, st_reg.s1_fb, st_reg.alpha); // RULE_09
				end else begin
					unique case (prb_ablend_type'(st_reg.mode[M_ABL_LO +: 2]))
						AB_NORMAL: draw = blend(draw, st_reg.s1_fb, st_reg.alpha); // RULE_11
						AB_STENCIL: draw = msb ? texc : st_reg.s1_fb; // RULE_11
						AB_STALPHA: draw = msb ? blend(texc, st_reg.s1_fb, st_reg.alpha)
							: st_reg.s1_fb; // RULE_12
						default: draw = blend(draw, st_reg.s1_fb, st_reg.alpha);
					endcase
				end
			end
			// 8-bit depth compares the low byte only
			zn = st_reg.depth[D_Z8] ? {8'h00, st_reg.s1_z[7:0]} : st_reg.s1_z; // RULE_16
			zo = st_reg.depth[D_Z8] ? {8'h00, st_reg.s1_zb[7:0]} : st_reg.s1_zb; // RULE_16
			unique case (st_reg.depth[D_CMP_LO +: ZCMP_W]) // RULE_14
				ZC_NEVER:    zpass = 1'b0;
				ZC_ALWAYS:   zpass = 1'b1;
				ZC_LESS:     zpass = zn < zo;
				ZC_LEQUAL:   zpass = zn <= zo;
				ZC_EQUAL:    zpass = zn == zo;
				ZC_GEQUAL:   zpass = zn >= zo;
				ZC_GREATER:  zpass = zn > zo;
				ZC_NOTEQUAL: zpass = zn != zo;
			endcase
			st_next.o_valid = 1'b1;
			st_next.o_fb_we = drawn && zpass;
			st_next.o_color = draw;
			st_next.o_zb_we = drawn && zpass && !st_reg.depth[D_INH]; // RULE_15
			st_next.o_z = zn;
			st_next.status[ST_DRAWN] = drawn;
			st_next.status[ST_ZPASS] = zpass;
		end else begin
			draw = st_reg.s1_poly;
			zn = st_reg.s1_z;
			zo = st_reg.s1_zb;
			zpass = 1'b0;
			drawn = 1'b0;
		end
		if (rst) begin
			st_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	assign reg_rdata = st_reg.rdata;
	assign out_valid = st_reg.o_valid;
	assign out_fb_we = st_reg.o_fb_we;
	assign out_color = st_reg.o_color;
	assign out_zb_we = st_reg.o_zb_we;
	assign out_z = st_reg.o_z;
endmodule

// ==== testbench/prb_core_asserts.sv ====
// Port-level checker for the pixel render back end
`timescale 1ns/100ps
module prb_core_asserts
	import prb_pkg::*;
(
	input wire logic              clk,          // Clock
	input wire logic              rst,          // Reset
	input wire logic [ADDR_W-1:0] reg_addr,     // Address
	input wire logic [31:0]       reg_wdata,    // Write data
	input wire logic              reg_wr,       // Write strobe
	input wire logic              reg_rd,       // Read strobe
	input wire logic [31:0]       reg_rdata,    // Read data
	input wire logic              pix_valid,    // Pixel in
	input wire logic [Z_W-1:0]    pix_z,        // Pixel depth
	input wire logic              pix_is_line,  // Line pixel
	input wire logic [4:0]        pix_dist,     // Centre distance
	input wire logic [4:0]        pix_dash_pos, // Dash position
	input wire logic              out_valid,    // Pixel out
	input wire logic              out_fb_we,    // Colour write
	input wire logic              out_zb_we,    // Depth write
	input wire logic [Z_W-1:0]    out_z         // Depth out
);
	// ****************************************
	// Shadow of the settings
	// ****************************************
	typedef struct packed {
		logic [4:0]  depth;
		logic [4:0]  width;
		logic [31:0] dash;
	} prb_shadow_type;
	prb_shadow_type sh_reg;
	prb_shadow_type sh_next;
	always_comb begin
		sh_next = sh_reg;
		if (reg_wr && reg_addr == REG_DEPTH) begin
			sh_next.depth = reg_wdata[4:0];
		end
		if (reg_wr && reg_addr == REG_LINE) begin
			sh_next.width = reg_wdata[4:0];
		end
		if (reg_wr && reg_addr == REG_DASH) begin
			sh_next.dash = reg_wdata;
		end
		if (rst) begin
			sh_next = '0;
		end
	end
	always_ff @(posedge clk) begin
		sh_reg <= sh_next;
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	unmapped_zero_a: assert property (reg_rd && reg_addr > REG_TEXWR |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	depth_readback_a: assert property (
		reg_rd && reg_addr == REG_DEPTH |=> reg_rdata[4:0] == $past(sh_reg.depth))
		else $error("depth settings read back wrong");
	out_latency_a: assert property (out_valid |-> $past(pix_valid, 2))
		else $error("result without a pixel two cycles before");
	fb_we_valid_a: assert property (out_fb_we |-> out_valid)
		else $error("colour write outside a result");
	z_drawn_a: assert property (out_zb_we |-> out_valid && out_fb_we)
		else $error("depth written for an undrawn pixel");
	never_draw_a: assert property (
		out_valid && sh_reg.depth[2:0] == ZC_NEVER |-> !out_fb_we && !out_zb_we)
		else $error("pixel drawn under never compare");
	inhibit_hold_a: assert property (out_valid && sh_reg.depth[3] |-> !out_zb_we)
		else $error("depth written while inhibited");
	z_value_a: assert property (
		out_zb_we && !sh_reg.depth[4] |-> out_z == $past(pix_z, 2))
		else $error("written depth differs from pixel depth");
	always_write_a: assert property (
		out_valid && sh_reg.depth == {2'b00, ZC_ALWAYS} && !$past(pix_is_line, 2)
		|-> out_zb_we)
		else $error("always compare did not write depth");
	line_drop_a: assert property (
		out_valid && $past(pix_is_line, 2) && (!sh_reg.dash[$past(pix_dash_pos, 2)]
		|| $past(pix_dist, 2) > sh_reg.width) |-> !out_fb_we)
		else $error("line pixel drawn outside width or dash");
endmodule

bind prb_core prb_core_asserts u_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .pix_valid, .pix_z, .pix_is_line, .pix_dist, .pix_dash_pos, .out_valid,
	.out_fb_we, .out_zb_we, .out_z);

// ==== testbench/prb_buf_model.sv ====
// Frame buffer and depth buffer model beside the render back end
`timescale 1ns/100ps
module prb_buf_model
	import prb_pkg::*;
(
	input  wire logic             clk,       // Clock
	input  wire logic             pix_valid, // Pixel request
	input  wire logic [11:0]      pix_x,     // Pixel address
	input  wire logic             out_valid, // Result pixel
	input  wire logic             out_fb_we, // Colour write
	input  wire logic [PIX_W-1:0] out_color, // Colour to store
	input  wire logic             out_zb_we, // Depth write
	input  wire logic [Z_W-1:0]   out_z,     // Depth to store
	output logic      [PIX_W-1:0] fb_color,  // Stored colour
	output logic      [Z_W-1:0]   zb_value   // Stored depth
);
	logic [PIX_W-1:0] fb_mem [64];
	logic [Z_W-1:0]   zb_mem [64];
	logic [5:0]       wq [$];
	logic [5:0]       wa;
	initial begin
		for (int i = 0; i < 64; i++) begin
			fb_mem[i] = 24'h5a0ff0 + 24'(i);
			zb_mem[i] = 16'h8000;
		end
	end
	// Inverse outside a request, so stale data cannot pass
	assign fb_color = pix_valid ? fb_mem[pix_x[5:0]] : ~fb_mem[pix_x[5:0]];
	assign zb_value = pix_valid ? zb_mem[pix_x[5:0]] : ~zb_mem[pix_x[5:0]];
	// Results return in request order; a queue pairs them
	always @(posedge clk) begin
		if (pix_valid) begin
			wq.push_back(pix_x[5:0]);
		end
		if (out_valid && wq.size() > 0) begin
			wa = wq.pop_front();
			if (out_fb_we) begin
				fb_mem[wa] <= out_color;
			end
			if (out_zb_we) begin
				zb_mem[wa] <= out_z;
			end
		end
	end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking testbench for the pixel render back end
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench
	import prb_pkg::*;
;
	localparam logic [31:0] GR = 32'h1 << M_GOURAUD;
	localparam logic [31:0] TX = 32'h1 << M_TEXEN;
	localparam logic [31:0] AD = (32'h1 << M_ALPHA) | (32'h1 << M_DIRECT);
	logic clk, rst, reg_wr, reg_rd, pix_valid, pix_is_line, pix_edge, pix_joint;
	logic pix_cap, pix_glyph, out_valid, out_fb_we, out_zb_we;
	logic [ADDR_W-1:0] reg_addr;
	logic [31:0]       reg_wdata, reg_rdata, rv;
	logic [11:0]       pix_x, pix_y;
	logic [PIX_W-1:0]  pix_color, pix_flat, fb_color, out_color;
	logic [15:0]       pix_s, pix_t, pix_q;
	logic [Z_W-1:0]    pix_z, zb_value, out_z;
	logic [4:0]        pix_dist, pix_dash_pos;
	int                bad_count, checks, px, lx;

	prb_core dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pix_valid, .pix_x, .pix_y, .pix_color, .pix_flat, .pix_s, .pix_t, .pix_q, .pix_z,
		.pix_is_line, .pix_dist, .pix_edge, .pix_dash_pos, .pix_joint, .pix_cap, .pix_glyph,
		.fb_color, .zb_value, .out_valid, .out_fb_we, .out_color, .out_zb_we, .out_z);
	prb_buf_model buffers (.clk, .pix_valid, .pix_x, .out_valid, .out_fb_we, .out_color,
		.out_zb_we, .out_z, .fb_color, .zb_value);

	always #20 clk = ~clk;

	// ****************************************
	// Reference functions and bus tasks
	// ****************************************
	function automatic logic [23:0] fbv(int i);
		return 24'h5a0ff0 + 24'(i);
	endfunction
	function automatic logic [23:0] lop(logic [3:0] c, logic [23:0] s, logic [23:0] d);
		for (int b = 0; b < 24; b++) begin
			lop[b] = c[{~s[b], ~d[b]}];
		end
	endfunction
	function automatic logic zp(logic [2:0] c, logic [15:0] z);
		case (c)
			ZC_NEVER: return 1'b0;
			ZC_ALWAYS: return 1'b1;
			ZC_LESS: return z < 16'h8000;
			ZC_LEQUAL: return z <= 16'h8000;
			ZC_EQUAL: return z == 16'h8000;
			ZC_GEQUAL: return z >= 16'h8000;
			ZC_GREATER: return z > 16'h8000;
			default: return z != 16'h8000;
		endcase
	endfunction
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// Fresh buffer address per pixel keeps the stored colour known
	task automatic pix(logic [23:0] c, logic [15:0] z = 16'h1, logic ln = 1'b0,
		logic [4:0] d = 5'h0, logic [4:0] p = 5'h0, logic [15:0] s = 16'h0);
		lx = px;
		px++;
		@(posedge clk);
		pix_x <= 12'(lx);
		pix_y <= 12'(lx);
		pix_color <= c;
		pix_flat <= ~c;
		pix_z <= z;
		pix_is_line <= ln;
		pix_dist <= d;
		pix_dash_pos <= p;
		pix_s <= s;
		pix_t <= 16'h0;
		pix_valid <= 1'b1;
		@(posedge clk);
		pix_valid <= 1'b0;
		for (int i = 0; i < 4 && out_valid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK(out_valid, 1'b1)
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		wr(REG_ALPHA, 32'h5a);
		wr(REG_DEPTH, 32'h1b);
		rd(REG_ALPHA);
		`CHK(rv[7:0], 8'h5a)
		rd(REG_DEPTH);
		`CHK(rv[4:0], 5'h1b)
		rd(4'hf);
		`CHK(rv, 32'h0)
	endtask
	task automatic t_rop;
		wr(REG_MODE, GR | (32'h1 << M_ROPEN));
		wr(REG_DEPTH, 32'(ZC_ALWAYS));
		for (int c = 0; c < 16; c++) begin
			wr(REG_ROP, 32'(c));
			pix(24'hc3a50f);
			`CHK(out_color, lop(4'(c), 24'hc3a50f, fbv(lx)))
		end
	endtask
	task automatic t_depth;
		logic [15:0] z;
		wr(REG_MODE, GR);
		for (int i = 0; i < 24; i++) begin
			z = 16'h7fff + 16'(i / 8);
			wr(REG_DEPTH, {28'h0, i[4], 3'(i)});
			pix(24'h123456, z);
			`CHK(out_fb_we, zp(3'(i), z))
			`CHK(out_zb_we, zp(3'(i), z) & ~i[4])
		end
	endtask
	task automatic t_alpha;
		wr(REG_MODE, AD);
		wr(REG_DEPTH, 32'(ZC_ALWAYS));
		wr(REG_ALPHA, 32'h0);
		pix(24'h3c5a96);
		`CHK(out_color, fbv(lx))
		wr(REG_ALPHA, 32'hff);
		pix(24'h3c5a96);
		`CHK(out_color, 24'hc3a569)
	endtask
	task automatic t_tex;
		logic [23:0] c;
		wr(REG_TEXWR, 32'h0000_1234);
		wr(REG_TEXWR, 32'h0001_9234);
		wr(REG_DEPTH, 32'h9);
		wr(REG_MODE, GR | TX | (32'h2 << M_TBL_LO));
		pix(24'h0f1e2d);
		`CHK(out_color, 24'h0f1e2d)
		wr(REG_MODE, GR | TX | AD | (32'h1 << M_ABL_LO));
		pix(24'h0f1e2d);
		`CHK(out_color, fbv(lx))
		wr(REG_MODE, GR | TX);
		pix(24'h0f1e2d, 16'h1, 1'b0, 5'h0, 5'h0, 16'h000c);
		c = out_color;
		`CHK(c == 24'h0f1e2d, 1'b0)
		pix(24'hf0e1d2, 16'h1, 1'b0, 5'h0, 5'h0, 16'h0014);
		`CHK(out_color, c)
	endtask
	task automatic t_line;
		wr(REG_MODE, GR);
		wr(REG_DEPTH, 32'(ZC_ALWAYS));
		wr(REG_LINE, 32'h3);
		wr(REG_DASH, 32'h8000_0001);
		pix(24'h0000ff, 16'h1, 1'b1, 5'd3);
		`CHK(out_fb_we, 1'b1)
		pix(24'h0000ff, 16'h1, 1'b1, 5'd4);
		`CHK(out_fb_we, 1'b0)
		pix(24'h0000ff, 16'h1, 1'b1, 5'd0, 5'd1);
		`CHK(out_fb_we, 1'b0)
		pix(24'h0000ff, 16'h1, 1'b1, 5'd0, 5'd31);
		`CHK(out_fb_we, 1'b1)
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{reg_wr, reg_rd, pix_valid, pix_is_line, pix_edge, pix_joint, pix_cap, pix_glyph} = '0;
		{reg_addr, reg_wdata, pix_x, pix_y, pix_color, pix_flat} = '0;
		{pix_s, pix_t, pix_z, pix_dist, pix_dash_pos} = '0;
		pix_q = 16'h0100;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_rop;
		t_depth;
		t_alpha;
		t_tex;
		t_line;
		stop_test;
	end
	// Far beyond the expected run
	initial begin
		#400000;
		bad_count++;
		stop_test;
	end
endmodule
